/* pfl_pkg.sv */
// Purpose: Shared constants and state types for the power-line frame link.
// Assumes: 10 MHz system clock taken from the modem master clock.
// Notes: The sample and default tick cycle counts are derived here from the nominal clock, baud rate and tick period.
package pfl_pkg;
    localparam int CLK_MHZ = 10;
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD_RATE = 1200;
    localparam int OVERSAMPLE = 16;
    localparam int SAMPLE_CYCLES = (CLK_HZ + BAUD_RATE * OVERSAMPLE / 2) / (BAUD_RATE * OVERSAMPLE);
    localparam int SAMPLE_W = 10;
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [3:0] SUB_MID = 4'h7;
    localparam logic [3:0] CHAR_BITS = 4'hB;
    localparam logic [3:0] RX_BITS = 4'hA;
    localparam logic [7:0] PREAMBLE_BYTE = 8'hFF;
    localparam logic [7:0] HEADER_BYTE = 8'hAA;
    localparam int BUF_DEPTH = 16;
    localparam int BUF_AW = 4;
    localparam logic [3:0] IDX_HOUSE = 4'h0;
    localparam logic [3:0] IDX_CTRL = 4'h1;
    localparam logic [3:0] IDX_SRC = 4'h2;
    localparam logic [3:0] IDX_DST = 4'h3;
    localparam logic [3:0] IDX_DATA = 4'h4;
    localparam logic [3:0] MAX_DATA = 4'hB;
    localparam logic [3:0] MAX_DATA_LAST = 4'hA;
    localparam logic [4:0] SEND_LEAD = 5'h02;
    localparam logic [4:0] SEND_TAIL = 5'h07;
    localparam logic [9:0] TIMER_LOAD = 10'h2FF;
    localparam logic [15:0] TIMER_STEPS = 16'h0300;
    localparam int TICK_PERIOD_NS = 555_560;
    localparam int TICK_CYCLES_DEF = (TICK_PERIOD_NS * CLK_MHZ + 500) / 1000;
    localparam int FIFO_WIDTH = 9;
    localparam int FIFO_DEPTH = 8;
    localparam logic [2:0] SYNC_IDLE = 3'h3;

    typedef enum logic [2:0] {TX_IDLE, TX_FILL, TX_HDR, TX_SUM, TX_SEND} pfl_tx_state_e;
    typedef enum logic [1:0] {RX_HUNT, RX_BODY, RX_OUT} pfl_rx_state_e;
endpackage

/* pfl_fifo.sv */
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: One clock; DEPTH is a power of two.
// Notes: Read data come straight from the storage flops.
module pfl_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    assign in_ready_out = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out = mem[rd_ptr];

    always_comb begin
        push = in_valid_in & in_ready_out;
        pop = out_valid_out & out_ready_in;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end
endmodule

/* pfl_byte_ram.sv */
// Purpose: Sixteen-byte frame buffer with one write and one registered read port.
// Assumes: One clock.
// Notes: Storage itself is not reset; only the read register is.
module pfl_byte_ram import pfl_pkg::*; (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic wr_en_in,
    input wire logic [BUF_AW-1:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [BUF_AW-1:0] rd_addr_in,
    output logic [7:0] rd_data_out
);
    logic [7:0] mem [BUF_DEPTH];

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out <= 8'h00;
        end else begin
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule

/* pfl_link.sv */
// Purpose: Controller-side framer and serial link to a half-duplex power-line modem.
// Assumes: Modem master clock at 10 MHz; modem pins are asynchronous to it.
// Notes: Payload enters through an 8-word FIFO; received frames leave as a byte stream.
module pfl_link import pfl_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] house_addr_in,
    input wire logic [7:0] link_ctrl_in,
    input wire logic [7:0] src_addr_in,
    input wire logic [7:0] dst_addr_in,
    input wire logic [7:0] header_compare_in,
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_last_in,
    output logic tx_ready_out,
    output logic rx_valid_out,
    output logic [7:0] rx_data_out,
    output logic rx_last_out,
    input wire logic rx_ready_in,
    output logic txd_out,
    input wire logic rxd_in,
    output logic rxtx_select_out,
    input wire logic carrier_detect_n_in,
    input wire logic modem_reset_out_in,
    output logic modem_watchdog_kick_out,
    output logic tick_irq_out,
    output logic carrier_irq_input_out,
    output logic controller_reset_req_out,
    output logic tx_buffer_empty_event_out,
    output logic header_match_event_out,
    output logic byte_received_event_out
);
    // Bit 0 receive data, bit 1 carrier detect, bit 2 modem reset.
    logic [2:0] sync_a, sync_b, sync_prev;
    logic carrier_evt, next_carrier_evt, rst_evt, next_rst_evt;
    logic [SAMPLE_W-1:0] samp_cnt, next_samp_cnt;
    logic samp_tick;
    logic [15:0] acc, next_acc;
    logic [16:0] acc_sum;
    logic [9:0] tmr, next_tmr;
    logic tick, next_tick, kick, next_kick;
    logic [10:0] tx_shift, next_tx_shift;
    logic [3:0] tx_bits, next_tx_bits, tx_sub, next_tx_sub;
    logic tx_busy, next_tx_busy, tx_done, next_tx_done, tx_load;
    logic [7:0] tx_byte;
    logic rx_act, next_rx_act, rx_done, next_rx_done, rx_err, next_rx_err;
    logic [3:0] rx_sub, next_rx_sub, rx_cnt, next_rx_cnt;
    logic [9:0] rx_sh, next_rx_sh;
    logic [7:0] rx_byte, next_rx_byte;
    logic hm_evt, next_hm_evt;
    pfl_tx_state_e tx_st, next_tx_st;
    logic [3:0] tx_n, next_tx_n;
    logic [4:0] tx_idx, next_tx_idx;
    logic [7:0] tx_sum, next_tx_sum;
    logic sel, next_sel;
    logic tw_en, f_valid, f_ready;
    logic [3:0] tw_addr;
    logic [7:0] tw_data, tr_data;
    logic [8:0] f_data;
    pfl_rx_state_e rx_st, next_rx_st;
    logic [3:0] r_idx, next_r_idx, r_len, next_r_len;
    logic [7:0] r_sum, next_r_sum;
    logic r_pend, next_r_pend, rw_en;

    pfl_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(tx_valid_in),
        .in_data_in({tx_last_in, tx_data_in}),
        .in_ready_out(tx_ready_out),
        .out_valid_out(f_valid),
        .out_data_out(f_data),
        .out_ready_in(f_ready)
    );

    pfl_byte_ram u_tx_buf (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .wr_en_in(tw_en),
        .wr_addr_in(tw_addr),
        .wr_data_in(tw_data),
        .rd_addr_in(4'(tx_idx - SEND_LEAD)),
        .rd_data_out(tr_data)
    );

    pfl_byte_ram u_rx_buf (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .wr_en_in(rw_en),
        .wr_addr_in(r_idx),
        .wr_data_in(rx_byte),
        .rd_addr_in(r_idx),
        .rd_data_out(rx_data_out)
    );

    // Synchronisers, modem line edges, sample divider and tick timer.
    always_comb begin
        next_carrier_evt = sync_prev[1] & ~sync_b[1];
        next_rst_evt = ~sync_prev[2] & sync_b[2];
        samp_tick = (samp_cnt == SAMPLE_W'(SAMPLE_CYCLES - 1));
        next_samp_cnt = samp_tick ? '0 : samp_cnt + 1'b1;
        // A fractional prescaler spreads 768 count steps evenly over one tick period.
        acc_sum = {1'b0, acc} + {1'b0, TIMER_STEPS};
        next_acc = acc_sum[15:0];
        next_tmr = tmr;
        next_tick = 1'b0;
        next_kick = kick;
        if (acc_sum >= 17'(TICK_CYCLES)) begin
            next_acc = 16'(acc_sum - 17'(TICK_CYCLES));
            if (tmr == '0) begin
                next_tmr = TIMER_LOAD;
                next_tick = 1'b1;
                // Toggling gives a falling edge every second tick, about 1.1 ms apart.
                next_kick = ~kick;
            end else begin
                next_tmr = tmr - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync_a <= SYNC_IDLE;
            sync_b <= SYNC_IDLE;
            sync_prev <= SYNC_IDLE;
            carrier_evt <= 1'b0;
            rst_evt <= 1'b0;
            samp_cnt <= '0;
            acc <= '0;
            tmr <= TIMER_LOAD;
            tick <= 1'b0;
            kick <= 1'b1;
        end else begin
            sync_a <= {modem_reset_out_in, carrier_detect_n_in, rxd_in};
            sync_b <= sync_a;
            sync_prev <= sync_b;
            carrier_evt <= next_carrier_evt;
            rst_evt <= next_rst_evt;
            samp_cnt <= next_samp_cnt;
            acc <= next_acc;
            tmr <= next_tmr;
            tick <= next_tick;
            kick <= next_kick;
        end
    end

    // Character transmitter; the shift register idles all ones so the line rests high.
    always_comb begin
        next_tx_shift = tx_shift;
        next_tx_bits = tx_bits;
        next_tx_sub = tx_sub;
        next_tx_busy = tx_busy;
        next_tx_done = 1'b0;
        if (tx_load) begin
            next_tx_shift = {1'b1, ~^tx_byte, tx_byte, 1'b0};
            next_tx_bits = CHAR_BITS;
            next_tx_sub = '0;
            next_tx_busy = 1'b1;
        end else if (tx_busy && samp_tick) begin
            next_tx_sub = tx_sub + 1'b1;
            if (tx_sub == SUB_LAST) begin
                next_tx_shift = {1'b1, tx_shift[10:1]};
                next_tx_bits = tx_bits - 1'b1;
                if (tx_bits == 4'h1) begin
                    next_tx_busy = 1'b0;
                    next_tx_done = 1'b1;
                end
            end
        end
        // A modem reset also drops a half-sent character, so the line rests high when select rises.
        if (rst_evt) begin
            next_tx_shift = '1;
            next_tx_busy = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_shift <= '1;
            tx_bits <= '0;
            tx_sub <= '0;
            tx_busy <= 1'b0;
            tx_done <= 1'b0;
        end else begin
            tx_shift <= next_tx_shift;
            tx_bits <= next_tx_bits;
            tx_sub <= next_tx_sub;
            tx_busy <= next_tx_busy;
            tx_done <= next_tx_done;
        end
    end

    // Character receiver, sixteen samples per bit, start bit checked at mid-bit.
    always_comb begin
        next_rx_act = rx_act;
        next_rx_sub = rx_sub;
        next_rx_cnt = rx_cnt;
        next_rx_sh = rx_sh;
        next_rx_byte = rx_byte;
        next_rx_err = rx_err;
        next_rx_done = 1'b0;
        next_hm_evt = 1'b0;
        if (samp_tick) begin
            if (!rx_act) begin
                if (!sync_b[0]) begin
                    next_rx_act = 1'b1;
                    next_rx_sub = '0;
                    next_rx_cnt = '0;
                end
            end else begin
                next_rx_sub = rx_sub + 1'b1;
                if (rx_cnt == '0 && rx_sub == SUB_MID) begin
                    next_rx_sub = '0;
                    next_rx_cnt = 4'h1;
                    next_rx_act = ~sync_b[0];
                end else if (rx_cnt != '0 && rx_sub == SUB_LAST) begin
                    next_rx_sh = {sync_b[0], rx_sh[9:1]};
                    next_rx_cnt = rx_cnt + 1'b1;
                    if (rx_cnt == RX_BITS) begin
                        next_rx_act = 1'b0;
                        next_rx_done = 1'b1;
                        next_rx_byte = next_rx_sh[7:0];
                        next_rx_err = ~(^next_rx_sh[8:0]) | ~next_rx_sh[9];
                        next_hm_evt = (next_rx_sh[7:0] == header_compare_in);
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_act <= 1'b0;
            rx_sub <= '0;
            rx_cnt <= '0;
            rx_sh <= '0;
            rx_byte <= 8'h00;
            rx_err <= 1'b0;
            rx_done <= 1'b0;
            hm_evt <= 1'b0;
        end else begin
            rx_act <= next_rx_act;
            rx_sub <= next_rx_sub;
            rx_cnt <= next_rx_cnt;
            rx_sh <= next_rx_sh;
            rx_byte <= next_rx_byte;
            rx_err <= next_rx_err;
            rx_done <= next_rx_done;
            hm_evt <= next_hm_evt;
        end
    end

    // Transmit framer: gather payload, add address fields and checksum, then send.
    always_comb begin
        next_tx_st = tx_st;
        next_tx_n = tx_n;
        next_tx_idx = tx_idx;
        next_tx_sum = tx_sum;
        f_ready = 1'b0;
        tw_en = 1'b0;
        tw_addr = IDX_HOUSE;
        tw_data = 8'h00;
        tx_load = 1'b0;
        tx_byte = tr_data;
        unique case (tx_st)
            TX_IDLE: begin
                next_tx_n = '0;
                next_tx_sum = 8'h00;
                if (f_valid) begin
                    next_tx_st = TX_FILL;
                end
            end
            TX_FILL: begin
                f_ready = 1'b1;
                tw_addr = IDX_DATA + tx_n;
                tw_data = f_data[7:0];
                if (f_valid) begin
                    tw_en = 1'b1;
                    next_tx_sum = tx_sum + f_data[7:0];
                    next_tx_n = tx_n + 1'b1;
                    if (f_data[8] || tx_n == MAX_DATA_LAST) begin
                        next_tx_st = TX_HDR;
                        next_tx_idx = '0;
                    end
                end
            end
            TX_HDR: begin
                tw_en = 1'b1;
                tw_addr = tx_idx[3:0];
                unique case (tx_idx[1:0])
                    2'h0: tw_data = house_addr_in;
                    2'h1: tw_data = {link_ctrl_in[7:4], tx_n};
                    2'h2: tw_data = src_addr_in;
                    2'h3: tw_data = dst_addr_in;
                endcase
                next_tx_sum = tx_sum + tw_data;
                next_tx_idx = tx_idx + 1'b1;
                if (tx_idx[1:0] == IDX_DST[1:0]) begin
                    next_tx_st = TX_SUM;
                end
            end
            TX_SUM: begin
                tw_en = 1'b1;
                tw_addr = IDX_DATA + tx_n;
                tw_data = tx_sum;
                next_tx_idx = '0;
                next_tx_st = TX_SEND;
            end
            TX_SEND: begin
                if (tx_idx == '0) begin
                    tx_byte = PREAMBLE_BYTE;
                end else if (tx_idx == 5'h01) begin
                    tx_byte = HEADER_BYTE;
                end
                if (!tx_busy) begin
                    if (tx_idx == SEND_TAIL + 5'(tx_n)) begin
                        next_tx_st = TX_IDLE;
                    end else begin
                        tx_load = 1'b1;
                        next_tx_idx = tx_idx + 1'b1;
                    end
                end
            end
        endcase
        if (rst_evt) begin
            next_tx_st = TX_IDLE;
        end
        next_sel = (next_tx_st != TX_SEND);
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_st <= TX_IDLE;
            tx_n <= '0;
            tx_idx <= '0;
            tx_sum <= 8'h00;
            sel <= 1'b1;
        end else begin
            tx_st <= next_tx_st;
            tx_n <= next_tx_n;
            tx_idx <= next_tx_idx;
            tx_sum <= next_tx_sum;
            sel <= next_sel;
        end
    end

    // Receive framer: hunt for the header, check fields, then hand the frame out.
    always_comb begin
        next_rx_st = rx_st;
        next_r_idx = r_idx;
        next_r_len = r_len;
        next_r_sum = r_sum;
        next_r_pend = r_pend;
        rw_en = 1'b0;
        unique case (rx_st)
            RX_HUNT: begin
                if (rx_done && hm_evt && !rx_err) begin
                    next_rx_st = RX_BODY;
                    next_r_idx = IDX_HOUSE;
                    next_r_sum = 8'h00;
                    next_r_len = '0;
                end
            end
            RX_BODY: begin
                if (rx_done) begin
                    rw_en = 1'b1;
                    next_r_sum = r_sum + rx_byte;
                    next_r_idx = r_idx + 1'b1;
                    if (r_idx == IDX_CTRL) begin
                        next_r_len = rx_byte[3:0];
                    end
                    if (rx_err) begin
                        next_rx_st = RX_HUNT;
                    end else if (r_idx == IDX_HOUSE && rx_byte != house_addr_in) begin
                        next_rx_st = RX_HUNT;
                    end else if (r_idx == IDX_CTRL && rx_byte[3:0] > MAX_DATA) begin
                        next_rx_st = RX_HUNT;
                    end else if (r_idx > IDX_CTRL && r_idx == IDX_DATA + r_len) begin
                        rw_en = 1'b0;
                        next_r_idx = '0;
                        next_r_pend = 1'b1;
                        next_rx_st = (rx_byte == r_sum) ? RX_OUT : RX_HUNT;
                    end
                end
            end
            RX_OUT: begin
                // The buffer read is registered, so each byte waits one cycle after its address.
                if (r_pend) begin
                    next_r_pend = 1'b0;
                end else if (rx_ready_in) begin
                    if (r_idx == IDX_DST + r_len) begin
                        next_rx_st = RX_HUNT;
                    end else begin
                        next_r_idx = r_idx + 1'b1;
                        next_r_pend = 1'b1;
                    end
                end
            end
        endcase
        if (rst_evt) begin
            next_rx_st = RX_HUNT;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_st <= RX_HUNT;
            r_idx <= '0;
            r_len <= '0;
            r_sum <= 8'h00;
            r_pend <= 1'b0;
        end else begin
            rx_st <= next_rx_st;
            r_idx <= next_r_idx;
            r_len <= next_r_len;
            r_sum <= next_r_sum;
            r_pend <= next_r_pend;
        end
    end

    assign rx_valid_out = (rx_st == RX_OUT) && !r_pend;
    assign rx_last_out = rx_valid_out && (r_idx == IDX_DST + r_len);
    assign txd_out = tx_shift[0];
    assign rxtx_select_out = sel;
    assign modem_watchdog_kick_out = kick;
    assign tick_irq_out = tick;
    assign carrier_irq_input_out = carrier_evt;
    assign controller_reset_req_out = rst_evt;
    assign tx_buffer_empty_event_out = tx_done;
    assign header_match_event_out = hm_evt;
    assign byte_received_event_out = rx_done;
endmodule

/* pfl_modem_model.sv */
// Purpose: Modem side of the serial link, sending characters on rxd.
// Assumes: Same 10 MHz clock as the link.
// Notes: Parity is always good; the line rests high between characters.
module pfl_modem_model import pfl_pkg::*; (
    input wire logic clk_in,
    output logic rxd_out
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BIT_CYCLES = OVERSAMPLE * SAMPLE_CYCLES;
    initial rxd_out = 1'b1;
    task automatic send_char(input logic [7:0] b);
        logic [10:0] fr;
        fr = {1'b1, ~^b, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk_in);
            rxd_out <= fr[i];
            repeat (BIT_CYCLES - 1) @(posedge clk_in);
        end
    endtask
endmodule

/* pfl_link_checker.sv */
// Purpose: Port-level assertions for the power-line frame link.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Tick spacing allows two cycles for fractional timer steps.
module pfl_link_checker #(
    parameter int TICK_CYCLES = 800
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic carrier_detect_n_in,
    input wire logic modem_reset_out_in,
    input wire logic txd_out,
    input wire logic rxtx_select_out,
    input wire logic modem_watchdog_kick_out,
    input wire logic tick_irq_out,
    input wire logic carrier_irq_input_out,
    input wire logic controller_reset_req_out,
    input wire logic tx_buffer_empty_event_out,
    input wire logic header_match_event_out,
    input wire logic byte_received_event_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int gap;
    int next_gap;
    always_comb next_gap = tick_irq_out ? 1 : gap + 1;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) gap <= 0;
        else gap <= next_gap;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    a_tick_spacing: assert property (
        tick_irq_out |-> gap >= TICK_CYCLES - 2 && gap <= TICK_CYCLES + 2) else $error("tick gap");
    a_tick_pulse: assert property (tick_irq_out |=> !tick_irq_out) else $error("tick");
    a_kick_follows: assert property (
        tick_irq_out |-> ##[0:2] $changed(modem_watchdog_kick_out)) else $error("kick");
    a_carrier_irq: assert property (
        $fell(carrier_detect_n_in) |-> ##[1:6] carrier_irq_input_out) else $error("carrier");
    a_reset_req: assert property (
        $rose(modem_reset_out_in) |-> ##[1:6] controller_reset_req_out) else $error("reset");
    a_empty_pulse: assert property (
        tx_buffer_empty_event_out |=> !tx_buffer_empty_event_out) else $error("empty");
    a_match_byte: assert property (
        header_match_event_out |-> byte_received_event_out) else $error("match");
    a_start_bit: assert property (
        $fell(rxtx_select_out) |-> ##[0:2] !txd_out) else $error("start");
    a_idle_high: assert property (rxtx_select_out |-> txd_out) else $error("idle");
    a_kick_width: assert property (
        $fell(modem_watchdog_kick_out) |=> (!modem_watchdog_kick_out) [*5]) else $error("kick width");
    c_tick: cover property (tick_irq_out);
    c_match: cover property (header_match_event_out);
    c_empty: cover property (tx_buffer_empty_event_out);
endmodule

bind pfl_link pfl_link_checker #(.TICK_CYCLES(TICK_CYCLES)) i_pfl_link_checker (
    .clk_in, .reset_n_in, .carrier_detect_n_in, .modem_reset_out_in, .txd_out,
    .rxtx_select_out, .modem_watchdog_kick_out, .tick_irq_out, .carrier_irq_input_out,
    .controller_reset_req_out, .tx_buffer_empty_event_out, .header_match_event_out,
    .byte_received_event_out);

/* powerline_frame_link_test.sv */
// Purpose: Self-checking bench for the power-line frame link.
// Assumes: 10 MHz clock; tick count shortened to 800 cycles.
// Notes: Only the preamble character and the next start bit are followed on the wire, a frame is too long.
module powerline_frame_link_test import pfl_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BIT_CYCLES = OVERSAMPLE * SAMPLE_CYCLES;
    logic clk_in = 1'b0, reset_n_in = 1'b0, tx_valid = 1'b0, tx_last = 1'b0;
    logic cdn = 1'b1, mrst = 1'b0, got = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic tx_ready, rx_valid, txd, rxd, sel, kick, tick, cirq, creq, tbe, hm, br;
    logic [1:0] seen;
    logic [3:0] rows [4] = '{4'h2, 4'h8, 4'hD, 4'h8};
    int n_fail = 0, checks = 0, cyc = 0;
    always #50 clk_in = ~clk_in;
    pfl_link #(.TICK_CYCLES(800)) i_pfl_link (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .house_addr_in(8'h21), .link_ctrl_in(8'h30), .src_addr_in(8'h01),
        .dst_addr_in(8'h02), .header_compare_in(HEADER_BYTE), .tx_valid_in(tx_valid),
        .tx_data_in(tx_data), .tx_last_in(tx_last), .tx_ready_out(tx_ready),
        .rx_valid_out(rx_valid), .rx_data_out(), .rx_last_out(), .rx_ready_in(rx_valid),
        .txd_out(txd), .rxd_in(rxd), .rxtx_select_out(sel), .carrier_detect_n_in(cdn),
        .modem_reset_out_in(mrst), .modem_watchdog_kick_out(kick), .tick_irq_out(tick),
        .carrier_irq_input_out(cirq), .controller_reset_req_out(creq),
        .tx_buffer_empty_event_out(tbe), .header_match_event_out(hm),
        .byte_received_event_out(br));
    pfl_modem_model i_pfl_modem_model (.clk_in(clk_in), .rxd_out(rxd));
    task automatic check(input logic [7:0] sv, input logic [7:0] ev);
        checks++;
        if (sv !== ev) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, sv, ev);
        end
    endtask
    task automatic finish_test();
        if (n_fail == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (br === 1'b1) begin
            check({7'h00, hm}, 8'h01);
            got <= 1'b1;
        end
        if (cyc == 99000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        check({3'h0, txd, sel, kick, tx_ready, rx_valid}, 8'h1E);
        for (int r = 0; r < 4; r++) begin
            cdn <= rows[r][3];
            mrst <= rows[r][2];
            seen = 2'b00;
            repeat (8) begin
                @(posedge clk_in);
                seen |= {cirq, creq};
            end
            check({6'h00, seen}, {6'h00, rows[r][1:0]});
        end
        while (tick !== 1'b1) @(posedge clk_in);
        repeat (3) @(posedge clk_in);
        check({7'h00, kick}, 8'h00);
        tx_data <= 8'h5A;
        tx_last <= 1'b1;
        tx_valid <= 1'b1;
        @(posedge clk_in);
        tx_valid <= 1'b0;
        fork i_pfl_modem_model.send_char(HEADER_BYTE); join_none
        while (sel !== 1'b0) @(posedge clk_in);
        tx_last <= 1'b0;
        tx_valid <= 1'b1;
        repeat (10) @(posedge clk_in);
        tx_valid <= 1'b0;
        check({7'h00, tx_ready}, 8'h00);
        repeat (4000) @(posedge clk_in);
        check({7'h00, txd}, 8'h00);
        for (int b = 1; b < 11; b++) begin
            repeat (BIT_CYCLES) @(posedge clk_in);
            check({7'h00, txd}, 8'h01);
        end
        while (tbe !== 1'b1) @(posedge clk_in);
        repeat (4000) @(posedge clk_in);
        check({7'h00, txd}, 8'h00);
        check({7'h00, got}, 8'h01);
        finish_test();
    end
endmodule
